// ==== hw/snms_pkg.sv ====
// package of constants for the sensor node message slave
package snms_pkg;
  localparam int          RX_DEPTH      = 8;
  localparam int          WR_DEPTH      = 4;
  localparam int          SAMPLE_DEPTH  = 16;
  localparam logic [6:0]  NODE_ADDR     = 7'h2A;
  localparam logic [3:0]  IDX_LEN       = 4'h1;
  localparam logic [3:0]  IDX_OFFS      = 4'h2;
  localparam logic [3:0]  IDX_DATA      = 4'h3;
  localparam logic [3:0]  FIXED_COUNT   = 4'h3;
  localparam int          BIT_DIR       = 7;
  localparam int          ST_INCOMPLETE = 0;
  localparam int          ST_OVFLW      = 1;
  localparam int          ST_CHKFAIL    = 2;
  localparam int          ST_DIR        = 3;
  localparam logic [7:0]  FILLER        = 8'h00;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [15:0] SUM_ZERO      = 16'h0000;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {SNMS_IDLE, SNMS_ADDR, SNMS_ACK, SNMS_RX, SNMS_TX, SNMS_TXACK} snms_state_t;
  typedef enum logic [1:0] {SNMS_PH_STATUS, SNMS_PH_DATA, SNMS_PH_SUM, SNMS_PH_FILL} snms_phase_t;
endpackage : snms_pkg

// ==== hw/snms_slave.sv ====
// message-layer I2C slave of a sensor node
`timescale 1ns/100ps
// Summary of operation
// R1: write address starts message: incomplete set, index reset, address stored, sum seeded.
// R2: write-addressed transaction suspends watchdog servicing.
// R3: receive overflow pins index at last slot and sets overflow flag.
// R4: length byte MSB sets direction flag: request or write.
// R5: request uses only lower seven length bits as count.
// R6: request expects three bytes counted from length byte.
// R7: write expects three plus data length bytes.
// R8: offset plus length past store end sets overflow flag.
// R9: at expected count, nonzero receive sum sets checksum failure.
// R10: valid complete write copies data into write store, else discarded.
// R11: master reads by addressing with direction bit set.
// R12: read match returns status, seeds transmit sum, resets sample index.
// R13: then sample bytes from offset and length, added to sum.
// R14: after samples, 16-bit transmit sum is sent.
// R15: further reads get filler bytes.
// R16: master NACK ends read and clears watchdog hold.
// R17: falling-edge slew limited while slew-limit-off bit is clear.
// R18: software should disable slew limiting above 400kHz.
// R19: master appends checksum making 8-bit message sum zero.
// R20: incomplete flag cleared only after full valid message.
module snms_slave
  import snms_pkg::*;
#(
  parameter logic [6:0] ADDR = NODE_ADDR
)(
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       CLK_EN,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  input  wire logic       SLEW_LIMIT_OFF,
  output logic            SLEW_LIMIT_EN,
  input  wire logic [7:0] SAMPLE_WDATA,
  input  wire logic [3:0] SAMPLE_WADDR,
  input  wire logic       SAMPLE_WVALID,
  output logic            SAMPLE_WREADY,
  output logic [7:0]      CMD_DATA,
  output logic            CMD_VALID,
  input  wire logic       CMD_READY,
  output logic [7:0]      STATUS,
  output logic            WDT_HOLD
);
  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [2:0] scl_q, scl_d, sda_q, sda_d;
  logic       scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  always_comb
  begin
    scl_d   = {scl_q[1:0], SCL_I};
    sda_d   = {sda_q[1:0], SDA_I};
    scl_s_d = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_s_q;
    sda_s_d = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_s_q;
  end
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_q   <= 3'h7;
      sda_q   <= 3'h7;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else if (CLK_EN)
    begin
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
    end
  end
  wire scl_rise = scl_s_d & ~scl_s_q;
  wire scl_fall = ~scl_s_d & scl_s_q;
  wire start_c  = scl_s_q & scl_s_d & sda_s_q & ~sda_s_d;
  wire stop_c   = scl_s_q & scl_s_d & ~sda_s_q & sda_s_d;

  // ***********************************************
  // stores
  // ***********************************************
  logic [7:0] sample_store [SAMPLE_DEPTH];
  logic [7:0] receive_store [RX_DEPTH];
  logic [7:0] write_store [WR_DEPTH];
  // sample store is loaded by node logic; never stalls
  always_ff @(posedge REF_CLK)
  begin
    if (CLK_EN && SAMPLE_WVALID)
      sample_store[SAMPLE_WADDR] <= SAMPLE_WDATA;
  end

  // ***********************************************
  // protocol engine
  // ***********************************************
  snms_state_t st_q, st_d;
  snms_phase_t ph_q, ph_d;
  logic [7:0]  sh_q, sh_d, stat_q, stat_d, len_q, len_d, offs_q, offs_d, rx_running_sum_q, rx_running_sum_d;
  logic [15:0] tx_running_sum_q, tx_running_sum_d;
  logic [3:0]  bit_q, bit_d, receive_index_q, receive_index_d, expected_rx_count_q, expected_rx_count_d;
  logic [3:0]  rx_cnt_q, rx_cnt_d;
  logic [7:0]  sample_read_index_q, sample_read_index_d;
  logic        rd_q, rd_d, wdt_q, wdt_d, sdo_q, sdo_d, sdoe_q, sdoe_d, sum_hi_q, sum_hi_d;
  logic        commit_q, commit_d;
  logic [2:0]  cp_q, cp_d;
  logic        bv_q, bv_d;
  logic [7:0]  bw_q, bw_d;
  logic [7:0]  byte_in, txb;
  logic        ob_full, push, pop;
  logic        rx_we;
  logic [2:0]  rx_widx;

  function automatic logic [7:0] sample_at(input logic [7:0] idx);
    sample_at = sample_store[idx[3:0]];
  endfunction : sample_at

  always_comb
  begin
    byte_in = {sh_q[6:0], sda_s_q};
    txb     = FILLER;
    st_d = st_q; ph_d = ph_q; sh_d = sh_q; stat_d = stat_q; len_d = len_q; offs_d = offs_q;
    rx_running_sum_d = rx_running_sum_q; tx_running_sum_d = tx_running_sum_q; bit_d = bit_q;
    receive_index_d = receive_index_q; expected_rx_count_d = expected_rx_count_q; rx_cnt_d = rx_cnt_q;
    sample_read_index_d = sample_read_index_q; rd_d = rd_q; wdt_d = wdt_q; sdo_d = sdo_q;
    sdoe_d = sdoe_q; sum_hi_d = sum_hi_q; commit_d = 1'b0;
    rx_we   = 1'b0;
    rx_widx = '0;
    unique case (ph_q)
      SNMS_PH_STATUS: txb = stat_q;
      SNMS_PH_DATA:   txb = sample_at(offs_q + sample_read_index_q);
      SNMS_PH_SUM:    txb = sum_hi_q ? tx_running_sum_q[15:8] : tx_running_sum_q[7:0];
      SNMS_PH_FILL:   txb = FILLER;
    endcase
    if (start_c)
    begin
      st_d = SNMS_ADDR; bit_d = '0; sdoe_d = 1'b0;
    end
    else if (stop_c)
    begin
      st_d = SNMS_IDLE; sdoe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        SNMS_IDLE: ;
        SNMS_ADDR, SNMS_RX:
          if (scl_rise)
          begin
            sh_d  = byte_in;
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == BITS_PER_BYTE)
          begin
            bit_d = '0;
            if (st_q == SNMS_ADDR && sh_q[7:1] != ADDR)
              st_d = SNMS_IDLE;
            else if (st_q == SNMS_ADDR && sh_q[0])
            begin
              // R12 status first, transmit sum and sample index restart
              rd_d = 1'b1; ph_d = SNMS_PH_STATUS; tx_running_sum_d = {8'h00, stat_q};
              sample_read_index_d = '0; sum_hi_d = 1'b0;
              sdo_d = 1'b0; sdoe_d = 1'b1; st_d = SNMS_ACK;
            end
            else if (st_q == SNMS_ADDR)
            begin
              // R1 new message
              rd_d = 1'b0; stat_d = '0; stat_d[ST_INCOMPLETE] = 1'b1;
              receive_index_d = '0; rx_cnt_d = '0; rx_running_sum_d = sh_q;
              // address byte kept in slot zero
              rx_we = 1'b1;
              expected_rx_count_d = FIXED_COUNT;
              // R2 watchdog servicing held
              wdt_d = 1'b1;
              sdo_d = 1'b0; sdoe_d = 1'b1; st_d = SNMS_ACK;
            end
            else
            begin
              rx_running_sum_d = rx_running_sum_q + sh_q;
              rx_cnt_d = rx_cnt_q + 4'h1;
              // R3 pin index, flag overflow
              if (receive_index_q == 4'(RX_DEPTH - 1))
                stat_d[ST_OVFLW] = 1'b1;
              else
                receive_index_d = receive_index_q + 4'h1;
              if (receive_index_q != 4'(RX_DEPTH - 1))
              begin
                rx_we   = 1'b1;
                rx_widx = receive_index_d[2:0];
              end
              if (rx_cnt_d == IDX_LEN)
              begin
                // R4 direction from msb
                stat_d[ST_DIR] = sh_q[BIT_DIR];
                // R5 R6 R7 count set up
                len_d = {1'b0, sh_q[6:0]};
                expected_rx_count_d = sh_q[BIT_DIR] ? FIXED_COUNT : FIXED_COUNT + sh_q[3:0];
              end
              if (rx_cnt_d == IDX_OFFS)
              begin
                // R8 bound check
                if ({1'b0, sh_q} + {1'b0, len_q} > (stat_q[ST_DIR] ? 9'(SAMPLE_DEPTH) : 9'(WR_DEPTH)))
                  stat_d[ST_OVFLW] = 1'b1;
                offs_d = sh_q;
              end
              if (rx_cnt_d == expected_rx_count_q)
              begin
                // R9 checksum test
                if (rx_running_sum_d != BYTE_ZERO)
                  stat_d[ST_CHKFAIL] = 1'b1;
                // R20 R10 valid message only
                else if (!stat_d[ST_OVFLW])
                begin
                  stat_d[ST_INCOMPLETE] = 1'b0;
                  commit_d = ~stat_q[ST_DIR];
                end
              end
              sdo_d = 1'b0; sdoe_d = 1'b1; st_d = SNMS_ACK;
            end
          end
        SNMS_ACK:
          if (scl_fall)
          begin
            if (rd_q)
            begin
              st_d = SNMS_TX; sdo_d = txb[7]; sdoe_d = ~txb[7]; sh_d = {txb[6:0], 1'b0}; bit_d = '0;
            end
            else
            begin
              st_d = SNMS_RX; sdoe_d = 1'b0;
            end
          end
        SNMS_TX:
          if (scl_fall)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q == BITS_PER_BYTE - 4'h1)
            begin
              st_d = SNMS_TXACK; sdoe_d = 1'b0;
            end
            else
            begin
              sdo_d = sh_q[7]; sdoe_d = ~sh_q[7]; sh_d = {sh_q[6:0], 1'b0};
            end
          end
        SNMS_TXACK:
          if (scl_rise)
          begin
            if (sda_s_q)
            begin
              // R16 nack ends transaction
              wdt_d = 1'b0; st_d = SNMS_IDLE;
            end
            else
            begin
              st_d = SNMS_ACK;
              unique case (ph_q)
                SNMS_PH_STATUS, SNMS_PH_DATA:
                begin
                  // R13 next sample added to sum
                  if (ph_q == SNMS_PH_DATA)
                    sample_read_index_d = sample_read_index_q + 8'h01;
                  if (sample_read_index_d < len_q)
                  begin
                    ph_d = SNMS_PH_DATA;
                    tx_running_sum_d = tx_running_sum_q + {8'h00, sample_at(offs_q + sample_read_index_d)};
                  end
                  // R14 then the sum
                  else
                    ph_d = SNMS_PH_SUM;
                end
                SNMS_PH_SUM:
                  if (sum_hi_q)
                    // R15 filler afterwards
                    ph_d = SNMS_PH_FILL;
                  else
                    sum_hi_d = 1'b1;
                SNMS_PH_FILL: ;
              endcase
            end
          end
        default: st_d = SNMS_IDLE;
      endcase
    end
    // copy engine: len_q[2:0] data bytes go out via the two-entry buffer
    cp_d = cp_q; bv_d = bv_q; bw_d = bw_q;
    if (bv_q && ob_full)
      bv_d = 1'b1;
    else if (cp_q != '0)
    begin
      bv_d = 1'b1; bw_d = receive_store[3'(IDX_DATA) + 3'(len_q[2:0]) - cp_q]; cp_d = cp_q - 3'h1;
    end
    else
      bv_d = 1'b0;
    if (commit_q)
      cp_d = 3'(len_q[2:0]);
  end
  // receive store written only at byte ends; read by the copy engine
  always_ff @(posedge REF_CLK)
  begin
    if (CLK_EN && rx_we)
      receive_store[rx_widx] <= sh_q;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q <= SNMS_IDLE; ph_q <= SNMS_PH_STATUS; sh_q <= '0; stat_q <= '0; len_q <= '0; offs_q <= '0;
      rx_running_sum_q <= '0; tx_running_sum_q <= SUM_ZERO; bit_q <= '0; receive_index_q <= '0;
      expected_rx_count_q <= FIXED_COUNT; rx_cnt_q <= '0; sample_read_index_q <= '0; rd_q <= 1'b0;
      wdt_q <= 1'b0; sdo_q <= 1'b1; sdoe_q <= 1'b0; sum_hi_q <= 1'b0; commit_q <= 1'b0;
      cp_q <= '0; bv_q <= 1'b0; bw_q <= '0;
    end
    else if (CLK_EN)
    begin
      st_q <= st_d; ph_q <= ph_d; sh_q <= sh_d; stat_q <= stat_d; len_q <= len_d; offs_q <= offs_d;
      rx_running_sum_q <= rx_running_sum_d; tx_running_sum_q <= tx_running_sum_d; bit_q <= bit_d;
      receive_index_q <= receive_index_d; expected_rx_count_q <= expected_rx_count_d; rx_cnt_q <= rx_cnt_d;
      sample_read_index_q <= sample_read_index_d; rd_q <= rd_d; wdt_q <= wdt_d; sdo_q <= sdo_d;
      sdoe_q <= sdoe_d; sum_hi_q <= sum_hi_d; commit_q <= commit_d;
      cp_q <= cp_d; bv_q <= bv_d; bw_q <= bw_d;
    end
  end

  // ***********************************************
  // two-entry write-store output buffer
  // ***********************************************
  logic [7:0] ob_q [2];
  logic [1:0] ob_cnt_q, ob_cnt_d;
  logic       ob_wp_q, ob_wp_d, ob_rp_q, ob_rp_d;
  logic [1:0] wi_q, wi_d;
  assign ob_full = (ob_cnt_q == 2'h2);
  assign push    = bv_q & ~ob_full;
  assign pop     = CMD_VALID & CMD_READY;
  always_comb
  begin
    ob_cnt_d = ob_cnt_q + {1'b0, push} - {1'b0, pop};
    ob_wp_d  = ob_wp_q ^ push;
    ob_rp_d  = ob_rp_q ^ pop;
    wi_d     = wi_q + {1'b0, push};
    if (commit_q)
      wi_d = '0;
  end
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ob_cnt_q <= '0; ob_wp_q <= 1'b0; ob_rp_q <= 1'b0; wi_q <= '0; CMD_VALID <= 1'b0; CMD_DATA <= '0;
    end
    else if (CLK_EN)
    begin
      ob_cnt_q  <= ob_cnt_d;
      ob_wp_q   <= ob_wp_d;
      ob_rp_q   <= ob_rp_d;
      wi_q      <= wi_d;
      CMD_VALID <= (ob_cnt_d != '0);
      // head is the arriving byte when it lands in the head slot
      if (push && ob_wp_q == ob_rp_d)
        CMD_DATA <= bw_q;
      else if (ob_cnt_d != '0)
        CMD_DATA <= ob_q[ob_rp_d];
    end
  end
  always_ff @(posedge REF_CLK)
  begin
    if (CLK_EN && push)
    begin
      ob_q[ob_wp_q]     <= bw_q;
      write_store[wi_q] <= bw_q;
    end
  end

  // ***********************************************
  // registered outputs
  // ***********************************************
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SDA_O <= 1'b1; SDA_OE <= 1'b0; STATUS <= '0; WDT_HOLD <= 1'b0; SLEW_LIMIT_EN <= 1'b1;
      SAMPLE_WREADY <= 1'b0;
    end
    else if (CLK_EN)
    begin
      SDA_O <= sdo_d; SDA_OE <= sdoe_d; STATUS <= stat_d; WDT_HOLD <= wdt_d;
      // R17 slew limit while bit clear
      SLEW_LIMIT_EN <= ~SLEW_LIMIT_OFF;
      SAMPLE_WREADY <= 1'b1;
    end
  end
endmodule : snms_slave

// ==== testbench/snms_slave_props.sv ====
// assertion checker for the message slave
`timescale 1ns/100ps
module snms_slave_props
  import snms_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  input wire logic       CLK_EN,
  input wire logic       SCL_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE,
  input wire logic       SLEW_LIMIT_OFF,
  input wire logic       SLEW_LIMIT_EN,
  input wire logic       CMD_VALID,
  input wire logic       CMD_READY,
  input wire logic [7:0] CMD_DATA,
  input wire logic [7:0] STATUS,
  input wire logic       WDT_HOLD
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  // data may only move while the bus clock has been low a while
  sequence s_scl_low;
    !SCL_I && !$past(SCL_I, 3);
  endsequence
  property p_slew; CLK_EN |=> SLEW_LIMIT_EN == !$past(SLEW_LIMIT_OFF); endproperty
  a_slew: assert property (p_slew) else $error("slew enable wrong");
  property p_sda; $changed(SDA_OE) |-> s_scl_low; endproperty
  a_sda: assert property (p_sda) else $error("data line moved with clock high");
  property p_start; $rose(STATUS[ST_INCOMPLETE]) |-> ##[0:2] WDT_HOLD; endproperty
  a_start: assert property (p_start) else $error("hold not set at message start");
  property p_done; $fell(STATUS[ST_INCOMPLETE]) |-> !STATUS[ST_CHKFAIL] && !STATUS[ST_OVFLW]; endproperty
  a_done: assert property (p_done) else $error("incomplete cleared on bad message");
  property p_chk; $rose(STATUS[ST_CHKFAIL]) |-> WDT_HOLD && STATUS[ST_INCOMPLETE]; endproperty
  a_chk: assert property (p_chk) else $error("checksum flag outside message");
  property p_ovf; $rose(STATUS[ST_OVFLW]) |-> STATUS[ST_INCOMPLETE]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag outside message");
  property p_dir; $changed(STATUS[ST_DIR]) |-> WDT_HOLD; endproperty
  a_dir: assert property (p_dir) else $error("direction changed outside message");
  property p_copy; $rose(CMD_VALID) |-> !STATUS[ST_CHKFAIL] && !STATUS[ST_OVFLW] && !STATUS[ST_DIR]; endproperty
  a_copy: assert property (p_copy) else $error("write data from bad message");
  property p_hold; CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_DATA); endproperty
  a_hold: assert property (p_hold) else $error("stalled command byte lost");
  property p_end; $fell(WDT_HOLD) |-> !(SDA_OE && !SDA_O); endproperty
  a_end: assert property (p_end) else $error("hold cleared while slave drives");
endmodule : snms_slave_props
bind snms_slave snms_slave_props props_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
  .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SLEW_LIMIT_OFF(SLEW_LIMIT_OFF),
  .SLEW_LIMIT_EN(SLEW_LIMIT_EN), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_DATA(CMD_DATA), .STATUS(STATUS), .WDT_HOLD(WDT_HOLD));

// ==== testbench/snms_master_model.sv ====
// bus master model for the message slave
`timescale 1ns/100ps
module snms_master_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // ****
  // bus master tasks
  // ****
  // half bit in clocks; the slave filter needs only two equal samples
  localparam int HALF = 64;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic start_cond();
    sda_low = 1'b0;
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask : start_cond
  // data moves a few clocks after the fall, never with it
  task automatic bit_io(input logic b, output logic r);
    wt(8);
    sda_low = !b;
    wt(HALF - 8);
    scl = 1'b1;
    wt(HALF / 2);
    r = sda_in;
    wt(HALF / 2);
    scl = 1'b0;
  endtask : bit_io
  // ninth bit: released for ack, or nack at end
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = r;
  endtask : byte_io
  task automatic stop_cond();
    wt(8);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask : stop_cond
endmodule : snms_master_model

// ==== testbench/sensor_node_message_slave_tb.sv ====
// testbench of the message slave
`timescale 1ns/100ps
module sensor_node_message_slave_tb;
  import snms_pkg::*;
  logic       ref_clk, rst_b, scl, sda_low, slew_off, swvalid, cmd_ready;
  logic       sda_o, sda_oe, slew_en, swready, cmd_valid, wdt;
  logic [7:0] swdata, cmd_data, status, rx;
  logic [3:0] swaddr;
  logic [7:0] msg[$];
  logic [7:0] rbuf[$];
  int         num_errors, check_count;
  wire        sda;
  // pulled-up open-drain line
  assign sda = !(sda_low || (sda_oe && !sda_o));
  snms_slave dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(1'b1), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SLEW_LIMIT_OFF(slew_off), .SLEW_LIMIT_EN(slew_en),
    .SAMPLE_WDATA(swdata), .SAMPLE_WADDR(swaddr), .SAMPLE_WVALID(swvalid), .SAMPLE_WREADY(swready),
    .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .STATUS(status), .WDT_HOLD(wdt));
  snms_master_model mm_u (.clk(ref_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
  // ****
  // helpers
  // ****
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic send_msg(input logic [7:0] len, input logic [7:0] offs, input int n, input logic bad);
    logic [7:0] sum;
    logic       a;
    sum = {NODE_ADDR, 1'b0};
    mm_u.start_cond();
    mm_u.byte_io(sum, 1'b1, rx, a);
    check("address ack", a, 1'b0);
    msg = {len, offs};
    for (int i = 0; i < n; i++)
      msg.push_back(8'h40 + 8'(i));
    foreach (msg[i])
      sum = sum + msg[i];
    msg.push_back(8'h00 - sum + {7'h00, bad});
    foreach (msg[i])
      mm_u.byte_io(msg[i], 1'b1, rx, a);
    mm_u.stop_cond();
  endtask : send_msg
  task automatic read_msg(input int n);
    logic a;
    rbuf = {};
    mm_u.start_cond();
    mm_u.byte_io({NODE_ADDR, 1'b1}, 1'b1, rx, a);
    for (int i = 0; i < n; i++)
    begin
      mm_u.byte_io(8'hFF, i == n - 1, rx, a);
      rbuf.push_back(rx);
    end
    mm_u.stop_cond();
  endtask : read_msg
  // ****
  // scenarios
  // ****
  task automatic sc_reset_slew();
    check("reset status", status, 8'h00);
    check("reset hold", wdt, 1'b0);
    check("slew on", slew_en, 1'b1);
    slew_off = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("slew off", slew_en, 1'b0);
    slew_off = 1'b0;
  endtask : sc_reset_slew
  task automatic sc_request();
    logic [15:0] sum;
    for (int i = 0; i < SAMPLE_DEPTH; i++)
    begin
      swaddr = 4'(i);
      swdata = 8'h30 + 8'(i);
      swvalid = 1'b1;
      for (int k = 0; k < 50 && swready !== 1'b1; k++)
        @(negedge ref_clk);
      @(negedge ref_clk);
    end
    swvalid = 1'b0;
    send_msg(8'h83, 8'h05, 0, 1'b0);
    check("request status", status, 8'h08);
    read_msg(7);
    sum = 16'h0008;
    check("status byte", rbuf[0], 8'h08);
    for (int i = 1; i < 4; i++)
    begin
      check("sample", rbuf[i], 8'h34 + 8'(i));
      sum = sum + 16'h0034 + 16'(i);
    end
    check("sum low", rbuf[4], sum[7:0]);
    check("sum high", rbuf[5], sum[15:8]);
    check("filler", rbuf[6], FILLER);
    check("hold end", wdt, 1'b0);
  endtask : sc_request
  task automatic sc_write();
    cmd_ready = 1'b0;
    send_msg(8'h04, 8'h00, 4, 1'b0);
    check("hold", wdt, 1'b1);
    check("write status", status, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      for (int k = 0; k < 400 && cmd_valid !== 1'b1; k++)
        @(negedge ref_clk);
      check("command valid", cmd_valid, 1'b1);
      check("command byte", cmd_data, 8'h40 + 8'(i));
      cmd_ready = 1'b1;
      @(negedge ref_clk);
      cmd_ready = 1'b0;
      @(negedge ref_clk);
    end
    repeat (4) @(negedge ref_clk);
    check("command empty", cmd_valid, 1'b0);
    read_msg(1);
    check("status byte", rbuf[0], 8'h00);
  endtask : sc_write
  task automatic sc_error(input logic [7:0] len, offs, input int n, input logic bad, input logic [7:0] mask, exp);
    send_msg(len, offs, n, bad);
    check("error status", status & mask, exp);
    check("no copy", cmd_valid, 1'b0);
    read_msg(1);
    check("hold end", wdt, 1'b0);
  endtask : sc_error
  initial
  begin
    rst_b = 1'b0;
    slew_off = 1'b0;
    swvalid = 1'b0;
    swaddr = 4'h0;
    swdata = 8'h00;
    cmd_ready = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    sc_reset_slew();
    sc_request();
    sc_write();
    sc_error(8'h01, 8'h00, 1, 1'b1, 8'h07, 8'h05);
    sc_error(8'h84, 8'h0E, 0, 1'b0, 8'h0A, 8'h0A);
    sc_error(8'h02, 8'h03, 2, 1'b0, 8'h0A, 8'h02);
    sc_error(8'h81, 8'h00, 6, 1'b0, 8'h02, 8'h02);
    report_and_stop();
  end
  // run is about 70k clocks; a hang ends well past that
  initial
  begin
    #900_000;
    num_errors++;
    report_and_stop();
  end
endmodule : sensor_node_message_slave_tb
